// ---- duic_aux_intr.sv ----
// Auxiliary control, input change capture and interrupt status/mask logic
`timescale 1ns/1ps
module duic_aux_intr
#(
   parameter int REF_DIV_W = 16
)
(
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   clkEn,
   // AXI4-Lite slave
   input  wire duic_pkg::duic_axi_req_t axiReq,
   output      duic_pkg::duic_axi_rsp_t axiRsp,
   // Pins and channel events
   input  wire logic [3:0]             inputPin,
   input  wire logic                   referenceClockIn,
   input  wire logic                   chanATxBitClock,
   input  wire logic                   chanBTxBitClock,
   input  wire duic_pkg::duic_chan_t   chanA,
   input  wire duic_pkg::duic_chan_t   chanB,
   // Outputs
   output      logic                   irqOutN_o,
   output      logic                   irqOutN_oe,
   output      logic                   rateSetSel,
   output      logic                   rateClk16x,
   output      logic [2:0]             ctSelect,
   output      logic                   ctOutput,
   output      logic [7:0]             programmableIrq
);
   import duic_pkg::*;

   // Two-flop synchronisers for pins and foreign clocks
   logic [6:0] syncA_r;
   logic [6:0] syncB_r;
   logic [6:0] syncC_r;
   wire  [6:0] rawIn = {chanBTxBitClock, chanATxBitClock, referenceClockIn, inputPin};
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         syncA_r <= 7'h00;
         syncB_r <= 7'h00;
         syncC_r <= 7'h00;
      end
      else if (clkEn)
      begin
         syncA_r <= rawIn;
         syncB_r <= syncA_r;
         syncC_r <= syncB_r;
      end
   end
   wire [3:0] pinLevel = syncB_r[3:0];
   wire [6:0] rise     = syncB_r & ~syncC_r;

   // Registers
   logic [7:0]  auxCtrl_r;
   logic [7:0]  intMask_r;
   logic [7:0]  intStatus_r;
   logic [7:0]  intStatus_nxt;
   logic [3:0]  chgFlag_r;
   logic [15:0] preset_r;
   logic [15:0] count_r;
   logic [3:0]  pre16_r;
   logic        ctRun_r;
   logic        sqWave_r;
   logic        cntRdyRise;

   // Bus handshake: write taken once both halves present
   logic        awHeld_r;
   logic        wHeld_r;
   logic [5:0]  awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic        bValid_r;
   logic [1:0]  bResp_r;
   logic        rValid_r;
   logic [31:0] rData_r;
   logic [1:0]  rResp_r;
   wire awTake  = axiReq.awvalid && !awHeld_r && !bValid_r;
   wire wTake   = axiReq.wvalid && !wHeld_r && !bValid_r;
   wire wrFire  = awHeld_r && wHeld_r;
   wire arTake  = axiReq.arvalid && !rValid_r;
   wire [5:0] rdAddr = axiReq.araddr;
   wire rdInput = arTake && rdAddr == ADDR_INPUT_CHG;
   wire stopCmd  = arTake && rdAddr == ADDR_STOP_CTR;
   wire startCmd = arTake && rdAddr == ADDR_START_CTR;
   wire wrAux    = wrFire && awAddr_r == ADDR_AUX_CTRL && wStrb_r[0];
   wire wrMask   = wrFire && awAddr_r == ADDR_INT_MASK && wStrb_r[0];
   wire wrPreLo  = wrFire && awAddr_r == ADDR_CTR_PRESET && wStrb_r[0];
   wire wrPreHi  = wrFire && awAddr_r == ADDR_CTR_PRESET && wStrb_r[1];
   wire wrCmd    = wrFire && awAddr_r == ADDR_CHAN_CMD && wStrb_r[0];
   wire brkClrA  = wrCmd && wData_r[CMD_BRK_A];
   wire brkClrB  = wrCmd && wData_r[CMD_BRK_B];

   function automatic logic wrMapped(input logic [5:0] a);
      wrMapped = a == ADDR_AUX_CTRL || a == ADDR_INT_MASK || a == ADDR_CTR_PRESET
                 || a == ADDR_CHAN_CMD;
   endfunction
   function automatic logic rdMapped(input logic [5:0] a);
      rdMapped = a == ADDR_AUX_CTRL || a == ADDR_INPUT_CHG || a == ADDR_INT_STATUS
                 || a == ADDR_INT_MASK || a == ADDR_CTR_PRESET || a == ADDR_START_CTR
                 || a == ADDR_STOP_CTR;
   endfunction

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         awHeld_r <= 1'b0;
         wHeld_r  <= 1'b0;
         awAddr_r <= 6'h00;
         wData_r  <= 32'h0000_0000;
         wStrb_r  <= 4'h0;
         bValid_r <= 1'b0;
         bResp_r  <= RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (awTake)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= axiReq.awaddr;
         end
         if (wTake)
         begin
            wHeld_r <= 1'b1;
            wData_r <= axiReq.wdata;
            wStrb_r <= axiReq.wstrb;
         end
         if (wrFire)
         begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            bValid_r <= 1'b1;
            bResp_r  <= wrMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bValid_r && axiReq.bready)
            bValid_r <= 1'b0;
      end
   end

   // Read data: capture register low nibble is the live level at the read
   wire [7:0] inputChgView = {chgFlag_r, pinLevel};
   wire [31:0] rdMux =
      rdAddr == ADDR_AUX_CTRL   ? {24'h000000, auxCtrl_r} :
      rdAddr == ADDR_INPUT_CHG  ? {24'h000000, inputChgView} :
      rdAddr == ADDR_INT_STATUS ? {24'h000000, intStatus_r} :
      rdAddr == ADDR_INT_MASK   ? {24'h000000, intMask_r} :
      rdAddr == ADDR_CTR_PRESET ? {16'h0000, count_r} : 32'h0000_0000;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rValid_r <= 1'b0;
         rData_r  <= 32'h0000_0000;
         rResp_r  <= RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (arTake)
         begin
            rValid_r <= 1'b1;
            rData_r  <= rdMux;
            rResp_r  <= rdMapped(rdAddr) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rValid_r && axiReq.rready)
            rValid_r <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         auxCtrl_r <= RST_BYTE;
         intMask_r <= RST_BYTE;
         preset_r  <= RST_PRESET;
      end
      else if (clkEn)
      begin
         if (wrAux)
            auxCtrl_r <= wData_r[7:0];
         if (wrMask)
            intMask_r <= wData_r[7:0];
         if (wrPreLo)
            preset_r[7:0] <= wData_r[7:0];
         if (wrPreHi)
            preset_r[15:8] <= wData_r[15:8];
      end
   end

   // Rate generator: only the fastest rate of each set is made, per-channel selects live outside
   logic [REF_DIV_W-1:0] rateCnt_r;
   wire  [REF_DIV_W-1:0] rateHalf = auxCtrl_r[AUX_RATE_SET]
                                    ? REF_DIV_W'(RATE_DIV_SET2 / 2 - 1)
                                    : REF_DIV_W'(RATE_DIV_SET1 / 2 - 1);
   wire                  rateWrap = rateCnt_r >= rateHalf;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rateCnt_r  <= '0;
         rateClk16x <= 1'b0;
      end
      else if (clkEn && rise[4])
      begin
         if (rateWrap)
         begin
            rateCnt_r  <= '0;
            rateClk16x <= ~rateClk16x;
         end
         else
            rateCnt_r <= rateCnt_r + REF_DIV_W'(1);
      end
   end

   // Input change flags; a change in the read cycle survives the clear
   wire [3:0] pinChange = syncB_r[3:0] ^ syncC_r[3:0];
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         chgFlag_r <= 4'h0;
      else if (clkEn)
         chgFlag_r <= (rdInput ? 4'h0 : chgFlag_r) | pinChange;
   end

   // Counter/timer clock source and tick
   wire [2:0] ctSel = auxCtrl_r[AUX_CT_MSB:AUX_CT_LSB];
   wire       timerMode = ctSel[2];
   logic [3:0] div16_r;
   wire srcPin2 = rise[2];
   wire srcRef  = rise[4];
   wire srcTxA  = rise[5];
   wire srcTxB  = rise[6];
   wire preSrc  = (ctSel == CT_TMR_PIN216) ? srcPin2 : srcRef;
   wire preTick = preSrc && div16_r == 4'(DIV16 - 1);
   logic ctTick;
   always_comb
   begin
      case (duic_ctsel_t'(ctSel))
         CT_CNT_PIN2:   ctTick = srcPin2;
         CT_CNT_TXA:    ctTick = srcTxA;
         CT_CNT_TXB:    ctTick = srcTxB;
         CT_CNT_REF16:  ctTick = preTick;
         CT_TMR_PIN2:   ctTick = srcPin2;
         CT_TMR_PIN216: ctTick = preTick;
         CT_TMR_REF:    ctTick = srcRef;
         CT_TMR_REF16:  ctTick = preTick;
         default:       ctTick = 1'b0;
      endcase
   end
   wire atZero = count_r == TERM_COUNT;
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         div16_r  <= 4'h0;
         count_r  <= RST_PRESET;
         ctRun_r  <= 1'b0;
         sqWave_r <= 1'b0;
      end
      else if (clkEn)
      begin
         if (preSrc)
            div16_r <= div16_r + 4'h1;
         if (startCmd)
         begin
            count_r  <= preset_r;
            ctRun_r  <= 1'b1;
            sqWave_r <= 1'b0;
         end
         else if (stopCmd && !timerMode)
            ctRun_r <= 1'b0;
         else if (ctTick && (ctRun_r || timerMode))
         begin
            if (timerMode && atZero)
            begin
               count_r  <= preset_r;
               sqWave_r <= ~sqWave_r;
            end
            else
               count_r <= count_r - 16'h0001;
         end
      end
   end
   // Timer: once per period on alternate zeros; counter: at terminal count
   assign cntRdyRise = ctTick && (timerMode ? (atZero && sqWave_r)
                       : (ctRun_r && count_r == 16'h0001));

   // Interrupt status; hardware set wins over a clear in the same cycle
   wire inputChgSet = |(pinChange & auxCtrl_r[3:0]);
   function automatic logic rxBit(input duic_chan_t c, input logic cur);
      logic setR;
      logic setF;
      setR  = c.charIn || (c.pop && c.moreQueued);
      setF  = (c.charIn && c.fifoFull) || c.waitingLoad;
      rxBit = (c.fifoFullMode ? setF : setR) || (cur && !c.pop);
   endfunction
   always_comb
   begin
      intStatus_nxt = intStatus_r;
      intStatus_nxt[ST_INPUT_CHG] = inputChgSet || (intStatus_r[ST_INPUT_CHG] && !rdInput);
      intStatus_nxt[ST_BRK_B] = chanB.breakChange || (intStatus_r[ST_BRK_B] && !brkClrB);
      intStatus_nxt[ST_BRK_A] = chanA.breakChange || (intStatus_r[ST_BRK_A] && !brkClrA);
      intStatus_nxt[ST_RX_B]  = rxBit(chanB, intStatus_r[ST_RX_B]);
      intStatus_nxt[ST_RX_A]  = rxBit(chanA, intStatus_r[ST_RX_A]);
      intStatus_nxt[ST_TX_B]  = chanB.txHoldingEmpty;
      intStatus_nxt[ST_TX_A]  = chanA.txHoldingEmpty;
      intStatus_nxt[ST_CTR]   = cntRdyRise || (intStatus_r[ST_CTR] && !stopCmd);
   end
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         intStatus_r <= RST_BYTE;
      else if (clkEn)
         intStatus_r <= intStatus_nxt;
   end

   // Pin outputs each from a flip-flop; bus ready strobes are combinational
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         irqOutN_o       <= 1'b0;
         irqOutN_oe      <= 1'b0;
         rateSetSel      <= 1'b0;
         ctSelect        <= 3'h0;
         ctOutput        <= 1'b1;
         programmableIrq <= RST_BYTE;
      end
      else if (clkEn)
      begin
         irqOutN_oe      <= |(intStatus_nxt & intMask_r);
         rateSetSel      <= auxCtrl_r[AUX_RATE_SET];
         ctSelect        <= ctSel;
         ctOutput        <= timerMode ? ~sqWave_r : !(ctRun_r && intStatus_nxt[ST_CTR]);
         programmableIrq <= intStatus_nxt;
      end
   end
   assign axiRsp = '{awready: awTake, wready: wTake, bvalid: bValid_r, bresp: bResp_r,
                     arready: arTake, rvalid: rValid_r, rdata: rData_r, rresp: rResp_r};

   // Checks
   a_irq_mask_gate: assert property (@(posedge mclk) disable iff (rst)
      clkEn |=> irqOutN_oe == |(intStatus_r & $past(intMask_r)))
      else $error("interrupt enable does not follow status and mask");
   a_irq_low_drive: assert property (@(posedge mclk) disable iff (rst)
      !irqOutN_o) else $error("interrupt pin driven high");
   a_chg_read_clear: assert property (@(posedge mclk) disable iff (rst)
      clkEn && rdInput && pinChange == 4'h0 |=> chgFlag_r == 4'h0)
      else $error("change flags not cleared by read");
   a_isr7_read_clr: assert property (@(posedge mclk) disable iff (rst)
      clkEn && rdInput && !inputChgSet |=> !intStatus_r[ST_INPUT_CHG])
      else $error("input change status not cleared by read");
   a_isr7_gated: assert property (@(posedge mclk) disable iff (rst)
      clkEn && !intStatus_r[ST_INPUT_CHG] && (pinChange & auxCtrl_r[3:0]) == 4'h0
      |=> !intStatus_r[ST_INPUT_CHG]) else $error("disabled change set status");
   a_tx_mirror: assert property (@(posedge mclk) disable iff (rst)
      clkEn |=> intStatus_r[ST_TX_A] == $past(chanA.txHoldingEmpty))
      else $error("tx ready not mirrored");
   a_stop_clears: assert property (@(posedge mclk) disable iff (rst)
      clkEn && stopCmd && !cntRdyRise |=> !intStatus_r[ST_CTR])
      else $error("stop command did not clear counter ready");
   a_start_loads: assert property (@(posedge mclk) disable iff (rst)
      clkEn && startCmd |=> count_r == $past(preset_r) && ctRun_r)
      else $error("start did not load preset");
   a_timer_runs: assert property (@(posedge mclk) disable iff (rst)
      clkEn && stopCmd && timerMode && ctTick |=> count_r != $past(count_r))
      else $error("stop halted the timer");
   a_brk_hold: assert property (@(posedge mclk) disable iff (rst)
      clkEn && intStatus_r[ST_BRK_A] && !brkClrA |=> intStatus_r[ST_BRK_A])
      else $error("break change bit lost");
   c_irq_seen:  cover property (@(posedge mclk) disable iff (rst) irqOutN_oe);
   c_ctr_ready: cover property (@(posedge mclk) disable iff (rst) cntRdyRise);
   c_chg_read:  cover property (@(posedge mclk) disable iff (rst) rdInput && |chgFlag_r);
endmodule

// ---- duic_pkg.sv ----
// Package for the auxiliary control and interrupt block
package duic_pkg;
   // Register byte addresses on the AXI4-Lite port
   localparam logic [5:0] ADDR_AUX_CTRL    = 6'h00;
   localparam logic [5:0] ADDR_INPUT_CHG   = 6'h04;
   localparam logic [5:0] ADDR_INT_STATUS  = 6'h08;
   localparam logic [5:0] ADDR_INT_MASK    = 6'h0c;
   localparam logic [5:0] ADDR_CTR_PRESET  = 6'h10;
   localparam logic [5:0] ADDR_START_CTR   = 6'h18;
   localparam logic [5:0] ADDR_STOP_CTR    = 6'h3c;
   localparam logic [5:0] ADDR_CHAN_CMD    = 6'h20;
   // Field positions
   localparam int AUX_RATE_SET  = 7;
   localparam int AUX_CT_MSB    = 6;
   localparam int AUX_CT_LSB    = 4;
   localparam int ST_INPUT_CHG  = 7;
   localparam int ST_BRK_B      = 6;
   localparam int ST_RX_B       = 5;
   localparam int ST_TX_B       = 4;
   localparam int ST_CTR        = 3;
   localparam int ST_BRK_A      = 2;
   localparam int ST_RX_A       = 1;
   localparam int ST_TX_A       = 0;
   localparam int CMD_BRK_A     = 0;
   localparam int CMD_BRK_B     = 1;
   // Reset values
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RST_PRESET = 16'h0002;
   localparam logic [15:0] TERM_COUNT = 16'h0000;
   localparam logic [1:0]  RESP_OKAY  = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   // Reference clock and rates
   localparam real REF_CLK_MHZ    = 3.6864;
   localparam real MCLK_MHZ       = 50.0;
   localparam int  DIV16          = 16;
   localparam int  RATE_TABLE_LEN = 16;
   // Reference cycles per 16x period of the fastest rate in each set
   localparam int  RATE_DIV_SET1  = 6;
   localparam int  RATE_DIV_SET2  = 12;
   // Counter/timer clock source selection
   typedef enum logic [2:0]
   {
      CT_CNT_PIN2   = 3'h0,
      CT_CNT_TXA    = 3'h1,
      CT_CNT_TXB    = 3'h2,
      CT_CNT_REF16  = 3'h3,
      CT_TMR_PIN2   = 3'h4,
      CT_TMR_PIN216 = 3'h5,
      CT_TMR_REF    = 3'h6,
      CT_TMR_REF16  = 3'h7
   } duic_ctsel_t;
   // Channel receiver and transmitter events
   typedef struct packed
   {
      logic charIn;
      logic fifoFull;
      logic pop;
      logic moreQueued;
      logic waitingLoad;
      logic breakChange;
      logic fifoFullMode;
      logic txHoldingEmpty;
   } duic_chan_t;
   // AXI4-Lite request side
   typedef struct packed
   {
      logic       awvalid;
      logic [5:0] awaddr;
      logic       wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic       bready;
      logic       arvalid;
      logic [5:0] araddr;
      logic       rready;
   } duic_axi_req_t;
   typedef struct packed
   {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } duic_axi_rsp_t;
endpackage

// ---- duic_host_model.sv ----
// Host-side AXI4-Lite master model for the register port
`timescale 1ns/1ps
module duic_host_model
(
   // Clock
   input  wire logic                    mclk,
   // Register bus
   output      duic_pkg::duic_axi_req_t axiReq,
   input  wire duic_pkg::duic_axi_rsp_t axiRsp,
   // Raised when an answer never comes
   output      logic                    hostHung
);
   import duic_pkg::*;
   localparam int WAIT_MAX = 200;

   initial
   begin
      axiReq   = '0;
      hostHung = 1'b0;
   end

   // Address and data offered together; each dropped once taken
   task automatic wr(input logic [5:0] a, input logic [7:0] v, output logic [1:0] resp);
      int i;
      begin
         resp = 2'b11;
         @(posedge mclk);
         axiReq.awvalid <= 1'b1;
         axiReq.awaddr  <= a;
         axiReq.wvalid  <= 1'b1;
         axiReq.wdata   <= {24'h0, v};
         axiReq.wstrb   <= 4'h1;
         axiReq.bready  <= 1'b1;
         for (i = 0; i < WAIT_MAX; i++)
         begin
            @(posedge mclk);
            if (axiRsp.awready)
               axiReq.awvalid <= 1'b0;
            if (axiRsp.wready)
               axiReq.wvalid <= 1'b0;
            if (axiRsp.bvalid)
            begin
               resp = axiRsp.bresp;
               axiReq.bready <= 1'b0;
               break;
            end
         end
         if (i == WAIT_MAX)
            hostHung = 1'b1;
         // Outputs launched at the answer edge settle before the caller looks
         #1;
      end
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
      int i;
      begin
         d    = '0;
         resp = 2'b11;
         @(posedge mclk);
         axiReq.arvalid <= 1'b1;
         axiReq.araddr  <= a;
         axiReq.rready  <= 1'b1;
         for (i = 0; i < WAIT_MAX; i++)
         begin
            @(posedge mclk);
            if (axiRsp.arready)
               axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid)
            begin
               d    = axiRsp.rdata;
               resp = axiRsp.rresp;
               axiReq.rready <= 1'b0;
               break;
            end
         end
         if (i == WAIT_MAX)
            hostHung = 1'b1;
         #1;
      end
   endtask
endmodule

// ---- dual_uart_interrupt_aux_control_test.sv ----
// Self-checking testbench for the auxiliary control and interrupt block
`timescale 1ns/1ps
module dual_uart_interrupt_aux_control_test;
   import duic_pkg::*;
   typedef struct packed
   {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdExp;
      logic [1:0] respExp;
   } duic_row_t;

   logic          mclk = 1'b0;
   logic          rst = 1'b1;
   logic          refClk = 1'b0;
   logic [3:0]    inputPin = 4'h0;
   duic_chan_t    chanA = '0;
   duic_chan_t    chanB = '0;
   duic_axi_req_t axiReq;
   duic_axi_rsp_t axiRsp;
   logic          irqOutN_o;
   logic          irqOutN_oe;
   logic          rateSetSel;
   logic [2:0]    ctSelect;
   logic          ctOutput;
   logic [7:0]    programmableIrq;
   logic          hostHung;
   logic          rateClk16x;
   logic          clkEn = 1'b1;
   int            halfCyc;
   logic [31:0]   d;
   logic [1:0]    r;
   int            fails = 0;
   int            checks = 0;
   int            i;
   duic_row_t     rows [6] = '{
      '{ADDR_AUX_CTRL, 8'h80, 8'h80, RESP_OKAY},
      '{ADDR_AUX_CTRL, 8'h7f, 8'h7f, RESP_OKAY},
      '{ADDR_INT_MASK, 8'hff, 8'hff, RESP_OKAY},
      '{ADDR_INT_MASK, 8'h00, 8'h00, RESP_OKAY},
      '{6'h2c, 8'h55, 8'h00, RESP_SLVERR},
      '{6'h14, 8'h55, 8'h00, RESP_SLVERR}};

   always #10 mclk = ~mclk;
   // Reference clock runs slower than mclk so the divided sources tick
   always @(posedge mclk) refClk <= ~refClk;

   duic_aux_intr i_dut
   (
      .mclk             (mclk),
      .rst              (rst),
      .clkEn            (clkEn),
      .axiReq           (axiReq),
      .axiRsp           (axiRsp),
      .inputPin         (inputPin),
      .referenceClockIn (refClk),
      .chanATxBitClock  (1'b0),
      .chanBTxBitClock  (1'b0),
      .chanA            (chanA),
      .chanB            (chanB),
      .irqOutN_o        (irqOutN_o),
      .irqOutN_oe       (irqOutN_oe),
      .rateSetSel       (rateSetSel),
      .rateClk16x       (rateClk16x),
      .ctSelect         (ctSelect),
      .ctOutput         (ctOutput),
      .programmableIrq  (programmableIrq)
   );

   duic_host_model i_host
   (
      .mclk     (mclk),
      .axiReq   (axiReq),
      .axiRsp   (axiRsp),
      .hostHung (hostHung)
   );

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic chkSt(input logic [7:0] e);
      i_host.rd(ADDR_INT_STATUS, d, r);
      chk(d[7:0], e);
   endtask

   // One-cycle channel event; level fields are kept as they were
   task automatic pulse(input logic chB, input logic [7:0] v);
      @(posedge mclk);
      if (chB)
         chanB <= duic_chan_t'(v | (chanB & 8'h03));
      else
         chanA <= duic_chan_t'(v | (chanA & 8'h03));
      @(posedge mclk);
      if (chB)
         chanB <= duic_chan_t'(chanB & 8'h03);
      else
         chanA <= duic_chan_t'(chanA & 8'h03);
   endtask

   // Half period of the 16x clock in mclk cycles; the bench reference is mclk/2
   task automatic rateHalf(input logic sel, output int n);
      logic v;
      int   k;
      begin
         i_host.wr(ADDR_AUX_CTRL, {sel, 7'h00}, r);
         repeat (30) @(posedge mclk);
         v = rateClk16x;
         for (k = 0; k < 40 && rateClk16x === v; k++)
            @(posedge mclk);
         v = rateClk16x;
         n = 0;
         for (k = 0; k < 40 && rateClk16x === v; k++)
         begin
            @(posedge mclk);
            n++;
         end
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge hostHung)
   begin
      fails++;
      give_verdict();
   end

   initial
   begin
      repeat (100000) @(posedge mclk);
      fails++;
      give_verdict();
   end

   initial
   begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      chkSt(8'h00);
      chk(irqOutN_oe, 1'b0);
      foreach (rows[k])
      begin
         i_host.wr(rows[k].addr, rows[k].wdata, r);
         chk(r, rows[k].respExp);
         i_host.rd(rows[k].addr, d, r);
         chk(r, rows[k].respExp);
         chk(d[7:0], rows[k].rdExp);
      end
      for (i = 0; i < 8; i++)
      begin
         i_host.wr(ADDR_AUX_CTRL, {i[0], i[2:0], 4'h0}, r);
         chk(ctSelect, i[2:0]);
         chk(rateSetSel, i[0]);
      end
      rateHalf(1'b0, halfCyc);
      chk(halfCyc, RATE_DIV_SET1);
      rateHalf(1'b1, halfCyc);
      chk(halfCyc, RATE_DIV_SET2);
      // Timer modes above may have set the counter bit; park and stop
      i_host.wr(ADDR_AUX_CTRL, 8'h01, r);
      i_host.rd(ADDR_STOP_CTR, d, r);
      @(posedge mclk) inputPin <= 4'h2;
      repeat (4) @(posedge mclk);
      chkSt(8'h00);
      i_host.rd(ADDR_INPUT_CHG, d, r);
      chk(d[7:0], 8'h22);
      i_host.rd(ADDR_INPUT_CHG, d, r);
      chk(d[7:0], 8'h02);
      @(posedge mclk) inputPin <= 4'h3;
      repeat (4) @(posedge mclk);
      chkSt(8'h80);
      chk(programmableIrq, 8'h80);
      chk(irqOutN_oe, 1'b0);
      i_host.rd(ADDR_INPUT_CHG, d, r);
      chk(d[7:0], 8'h13);
      chkSt(8'h00);
      @(posedge mclk)
      begin
         chanA <= duic_chan_t'(8'h01);
         chanB <= duic_chan_t'(8'h01);
      end
      chkSt(8'h11);
      i_host.wr(ADDR_INT_MASK, 8'h01, r);
      chk(irqOutN_oe, 1'b1);
      chk(irqOutN_o, 1'b0);
      i_host.wr(ADDR_INT_MASK, 8'hee, r);
      chk(irqOutN_oe, 1'b0);
      chk(programmableIrq, 8'h11);
      @(posedge mclk)
      begin
         chanA <= '0;
         chanB <= '0;
      end
      pulse(1'b1, 8'h04);
      pulse(1'b0, 8'h04);
      chkSt(8'h44);
      chk(irqOutN_oe, 1'b1);
      i_host.wr(ADDR_CHAN_CMD, 8'h02, r);
      chkSt(8'h04);
      i_host.wr(ADDR_CHAN_CMD, 8'h01, r);
      chkSt(8'h00);
      pulse(1'b0, 8'h80);
      pulse(1'b1, 8'h80);
      chkSt(8'h22);
      pulse(1'b0, 8'h30);
      pulse(1'b1, 8'h20);
      chkSt(8'h02);
      pulse(1'b0, 8'h20);
      chkSt(8'h00);
      @(posedge mclk) chanA <= duic_chan_t'(8'h02);
      pulse(1'b0, 8'h80);
      chkSt(8'h00);
      pulse(1'b0, 8'hc0);
      chkSt(8'h02);
      pulse(1'b0, 8'h20);
      chkSt(8'h00);
      pulse(1'b0, 8'h08);
      chkSt(8'h02);
      pulse(1'b0, 8'h20);
      // Timer from the reference: stop clears the bit but the timer keeps going
      i_host.wr(ADDR_AUX_CTRL, 8'h60, r);
      i_host.rd(ADDR_START_CTR, d, r);
      d = '0;
      for (i = 0; i < 60 && d[3] !== 1'b1; i++)
         i_host.rd(ADDR_INT_STATUS, d, r);
      chk(d[3], 1'b1);
      i_host.rd(ADDR_STOP_CTR, d, r);
      i_host.rd(ADDR_STOP_CTR, d, r);
      d = '0;
      for (i = 0; i < 60 && d[3] !== 1'b1; i++)
         i_host.rd(ADDR_INT_STATUS, d, r);
      chk(d[3], 1'b1);
      // Counter from reference/16, preset left at its reset value
      i_host.wr(ADDR_AUX_CTRL, 8'h30, r);
      i_host.rd(ADDR_STOP_CTR, d, r);
      i_host.rd(ADDR_START_CTR, d, r);
      d = '0;
      for (i = 0; i < 60 && d[3] !== 1'b1; i++)
         i_host.rd(ADDR_INT_STATUS, d, r);
      chk(d[3], 1'b1);
      chk(ctOutput, 1'b0);
      i_host.rd(ADDR_STOP_CTR, d, r);
      chkSt(8'h00);
      chk(ctOutput, 1'b1);
      // Frozen clock enable: a break event must leave no trace
      @(posedge mclk) clkEn <= 1'b0;
      pulse(1'b0, 8'h04);
      chk(programmableIrq, 8'h00);
      @(posedge mclk) clkEn <= 1'b1;
      chkSt(8'h00);
      pulse(1'b1, 8'h04);
      @(posedge mclk) rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      chkSt(8'h00);
      give_verdict();
   end
endmodule
